// ---- bench/qei_enc_model.sv ----
// Behavioural incremental encoder that drives one pair of timer inputs.
`timescale 1ns/1ns
module qei_enc_model (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Step requests from the bench, one-cycle pulses
  input wire logic step_fwd,
  input wire logic step_back,
  // Encoder phases
  output logic phase_a,
  output logic phase_b
);
  logic [1:0] pos_q;

  // One step per request, so every level is held for several clocks
  always_ff @(posedge mclk) begin
    if (rst) begin
      pos_q <= 2'h0;
    end else if (step_fwd) begin
      pos_q <= pos_q + 2'h1;
    end else if (step_back) begin
      pos_q <= pos_q - 2'h1;
    end
  end

  // Gray order 00,10,11,01 is forward; phases stay 90 degrees apart
  assign phase_a = pos_q[0] ^ pos_q[1];
  assign phase_b = pos_q[1];
endmodule

// ---- bench/quadrature_encoder_timer_interface_test.sv ----
// Self-checking bench for the quadrature encoder timer block.
`timescale 1ns/1ns
module quadrature_encoder_timer_interface_test;
  import qei_pkg::*;
  logic mclk;
  logic rst = 1'b1;
  logic [15:0] paddr = 16'h0000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  wire [2:0] cnt_pins;
  wire [2:0] dir_pins;
  logic [2:0] step_fwd = 3'h0;
  logic [2:0] step_back = 3'h0;
  wire [2:0] irq_v;
  int irq_n [3] = '{0, 0, 0};
  int bad_count = 0;
  int checked = 0;

  // Clock at 20 MHz
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  qei_timer dut_u (
    .mclk(mclk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .count_input_pin(cnt_pins), .direction_input_pin(dir_pins),
    .core_interrupt_request(irq_v[1]), .aux_a_interrupt_request(irq_v[0]),
    .aux_b_interrupt_request(irq_v[2])
  );

  // One encoder per timer, so the auxiliary inputs are exercised too
  for (genvar g = 0; g < 3; g++) begin : enc
    qei_enc_model enc_u (
      .mclk(mclk), .rst(rst), .step_fwd(step_fwd[g]), .step_back(step_back[g]),
      .phase_a(cnt_pins[g]), .phase_b(dir_pins[g])
    );
  end

  // Interrupt pulses last one cycle, so count them as they pass
  always @(posedge mclk) begin
    for (int i = 0; i < 3; i++) begin
      if (irq_v[i] === 1'b1) irq_n[i]++;
    end
  end

  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      bad_count++;
    end
  endtask

  // Request held until pready is sampled high, then released; a hang is left to the watchdog
  task xfer(input logic [15:0] a, input logic w, input logic [15:0] wd,
            output logic [31:0] rd, output logic err);
    @(posedge mclk);
    paddr <= a;
    pwrite <= w;
    pwdata <= {16'h0000, wd};
    psel <= 1'b1;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [15:0] a, input logic [15:0] d);
    logic [31:0] x;
    logic e;
    xfer(a, 1'b1, d, x, e);
  endtask

  task rchk(input logic [15:0] a, input logic [15:0] exp, input string nm);
    logic [31:0] x;
    logic e;
    xfer(a, 1'b0, 16'h0000, x, e);
    chk(nm, {16'h0000, exp}, x);
  endtask

  // Steps of encoder t; gaps keep each level stable well past one sample
  task move(input int t, input logic fwd, input int n);
    repeat (n) begin
      @(posedge mclk);
      step_fwd[t] <= fwd;
      step_back[t] <= !fwd;
      @(posedge mclk);
      step_fwd[t] <= 1'b0;
      step_back[t] <= 1'b0;
      repeat (2) @(posedge mclk);
    end
  endtask

  task t_reset;
    logic [15:0] map [6] = '{QEI_AUX_A_CTL, QEI_AUX_B_CTL, QEI_CORE_CTL,
                             QEI_CORE_CNT, QEI_AUX_A_CNT, QEI_AUX_B_CNT};
    logic [31:0] x;
    logic e;
    foreach (map[i]) rchk(map[i], 16'h0000, "reset value");
    xfer(16'hff58, 1'b0, 16'h0000, x, e);
    chk("unmapped data", 32'h0000_0000, x);
    chk("unmapped error", 32'h0000_0001, {31'h0, e});
    wr(QEI_CORE_CTL, 16'h8000);
    rchk(QEI_CORE_CTL, 16'h0000, "direction bit read only");
    $display("test reset done");
  endtask

  task t_rot;
    int i0;
    wr(QEI_CORE_CTL, 16'h0173);
    i0 = irq_n[1];
    move(1, 1'b1, 4);
    rchk(QEI_CORE_CNT, 16'h0004, "four-fold up count");
    rchk(QEI_CORE_CTL, 16'h2173, "edge flag");
    chk("no direction irq", i0, irq_n[1]);
    move(1, 1'b0, 1);
    rchk(QEI_CORE_CNT, 16'h0003, "down count");
    rchk(QEI_CORE_CTL, 16'he173, "direction change");
    chk("direction irq", i0 + 1, irq_n[1]);
    wr(QEI_CORE_CTL, 16'h0173);
    rchk(QEI_CORE_CTL, 16'h8173, "flags cleared");
    repeat (2) begin
      move(1, 1'b1, 1);
      move(1, 1'b0, 1);
    end
    rchk(QEI_CORE_CNT, 16'h0003, "jitter cancels");
    chk("jitter irqs", i0 + 5, irq_n[1]);
    $display("test rotation done");
  endtask

  task t_sel;
    logic [2:0] sels [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4};
    logic [15:0] exps [5] = '{16'h0000, 16'h0002, 16'h0002, 16'h0004, 16'h0000};
    foreach (sels[i]) begin
      wr(QEI_CORE_CNT, 16'h0000);
      wr(QEI_CORE_CTL, 16'h0170 | {13'h0, sels[i]});
      move(1, 1'b1, 4);
      rchk(QEI_CORE_CNT, exps[i], "input select");
    end
    $display("test select done");
  endtask

  task t_edge;
    int i0;
    wr(QEI_CORE_CNT, 16'h0000);
    wr(QEI_CORE_CTL, 16'h01fb);
    i0 = irq_n[1];
    move(1, 1'b1, 4);
    rchk(QEI_CORE_CNT, 16'hfffc, "inverted and wrapped");
    chk("edge irqs", i0 + 4, irq_n[1]);
    wr(QEI_CORE_CTL, 16'h11fb);
    move(1, 1'b1, 2);
    rchk(QEI_CORE_CNT, 16'hfffa, "count with irq off");
    rchk(QEI_CORE_CTL, 16'hb1fb, "status with irq off");
    chk("irq disabled", i0 + 4, irq_n[1]);
    $display("test edge done");
  endtask

  task t_aux;
    int i0;
    wr(QEI_AUX_A_CNT, 16'h1234);
    rchk(QEI_AUX_A_CNT, 16'h1234, "aux count write");
    wr(QEI_CORE_CTL, 16'h0173);
    wr(QEI_AUX_A_CTL, 16'h0333);
    move(0, 1'b1, 2);
    rchk(QEI_AUX_A_CNT, 16'h1236, "remote run on");
    wr(QEI_CORE_CTL, 16'h0133);
    move(0, 1'b1, 2);
    rchk(QEI_AUX_A_CNT, 16'h1236, "remote run off");
    wr(QEI_AUX_B_CTL, 16'h0173);
    wr(QEI_AUX_B_CNT, 16'h0000);
    i0 = irq_n[2];
    move(2, 1'b0, 2);
    rchk(QEI_AUX_B_CNT, 16'hfffe, "aux quadrature");
    rchk(QEI_AUX_B_CTL, 16'he173, "aux status bits");
    chk("aux irq", i0 + 1, irq_n[2]);
    chk("aux a no irq", 0, irq_n[0]);
    $display("test aux done");
  endtask

  // Plain modes of the auxiliary timers and their links to the core timer
  task t_modes;
    wr(QEI_AUX_B_CTL, 16'h0049);
    wr(QEI_AUX_B_CNT, 16'h0000);
    move(2, 1'b1, 4);
    rchk(QEI_AUX_B_CNT, 16'h0001, "counter rising edges");
    // A write lands at its access edge, the next one three edges later
    wr(QEI_AUX_B_CNT, 16'h0000);
    wr(QEI_AUX_B_CTL, 16'h0040);
    wr(QEI_AUX_B_CTL, 16'h0000);
    rchk(QEI_AUX_B_CNT, 16'h0003, "timer counts while run");
    // Pin is high: the low gate holds the count, the high gate lets it run
    wr(QEI_AUX_B_CNT, 16'h0000);
    wr(QEI_AUX_B_CTL, 16'h0050);
    wr(QEI_AUX_B_CTL, 16'h0058);
    wr(QEI_AUX_B_CTL, 16'h0000);
    rchk(QEI_AUX_B_CNT, 16'h0003, "gated timer");
    wr(QEI_AUX_A_CTL, 16'h0029);
    move(0, 1'b1, 1);
    rchk(QEI_AUX_A_CNT, 16'hfffa, "capture core count");
    wr(QEI_AUX_B_CTL, 16'h0020);
    wr(QEI_CORE_CNT, 16'hffff);
    wr(QEI_CORE_CTL, 16'h0173);
    move(1, 1'b1, 1);
    rchk(QEI_CORE_CNT, 16'h0003, "reload on wrap");
    $display("test modes done");
  endtask

  task stop_test;
    $display("checked %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Main sequence after reset
  initial begin
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    t_reset;
    t_rot;
    t_sel;
    t_edge;
    t_aux;
    t_modes;
    stop_test;
  end

  // Watchdog far beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge mclk);
    bad_count++;
    stop_test;
  end
endmodule

// ---- rtl/qei_pkg.sv ----
// Package for the quadrature encoder timer block: register map, fields, modes.
// Function
// [RL1] Core timer decodes quadrature when its mode field is 110 or 111.
// [RL2] Count on transitions of one or both inputs: 2-fold or 4-fold resolution.
// [RL3] Input select: 000 stop, 001 count pin, 010 direction pin, 011 both.
// [RL4] Transition order on both inputs yields count pulses and count direction.
// [RL5] Mode 110 raises the core interrupt on every direction change.
// [RL6] Mode 111 raises the core interrupt on every qualifying count edge.
// [RL7] Control register shows direction, direction-change flag and count-edge flag.
// [RL8] Software sets external direction enable before using quadrature mode.
// [RL9] Software configures both encoder pins as inputs beforehand.
// [RL10] Encoder holds each input level long enough for it to be seen.
// [RL11] Encoder frequency stays below half the maximum count frequency.
// [RL12] Count pin edge: rising counts down when direction pin high, else reversed.
// [RL13] Direction pin edge: rising counts up when count pin high, else reversed.
// [RL14] Jitter around a switching point gives opposite counts that cancel.
// [RL15] Both auxiliary timers are identical: timer, gated, counter, quadrature modes.
// [RL16] Auxiliary timers may concatenate with, reload or capture the core timer.
// [RL17] Auxiliary run may be taken over by the core run bit.
// [RL18] Auxiliary count registers read current value and accept writes anytime.
// [RL19] Common functions sit at the same bit positions in all control registers.
// [RL20] Auxiliary timers have no toggle latch and no output pin.
// [RL21] Direction-change flag set by hardware, held until software clears it.
// [RL22] Count-edge flag set by hardware, held until software clears it.
// [RL23] Interrupt-disable bit set suppresses quadrature interrupt requests.
// [RL24] With external direction enabled, the up/down bit inverts derived direction.
// [RL25] Inputs sampled each clock, edges by compare, one step per edge, wrapping.
// [RL26] Direction bit holds last edge direction; change compares against it.
package qei_pkg;
  // Byte addresses on the register bus
  localparam logic [15:0] QEI_AUX_A_CTL = 16'hff40;
  localparam logic [15:0] QEI_AUX_B_CTL = 16'hff44;
  localparam logic [15:0] QEI_CORE_CTL = 16'hff48;
  localparam logic [15:0] QEI_CORE_CNT = 16'hff4c;
  localparam logic [15:0] QEI_AUX_A_CNT = 16'hff50;
  localparam logic [15:0] QEI_AUX_B_CNT = 16'hff54;
  localparam logic [15:0] QEI_CTL_RESET = 16'h0000;
  localparam logic [15:0] QEI_CNT_RESET = 16'h0000;
  // Timer indices in the arrays
  localparam int QEI_AUX_A = 0;
  localparam int QEI_CORE = 1;
  localparam int QEI_AUX_B = 2;
  localparam int QEI_NTIM = 3;
  // Control field positions, shared by all three timers
  localparam int QEI_F_RDIR = 15;
  localparam int QEI_F_CHDIR = 14;
  localparam int QEI_F_EDGE = 13;
  localparam int QEI_F_IRDIS = 12;
  localparam int QEI_F_RC = 9;
  localparam int QEI_F_UDE = 8;
  localparam int QEI_F_UD = 7;
  localparam int QEI_F_RUN = 6;
  localparam int QEI_F_M_LO = 3;
  localparam int QEI_F_I_LO = 0;
  // Writable bits of a control word; the direction bit is hardware only
  localparam logic [15:0] QEI_CTL_WMASK = 16'h73ff;
  // Mode field codes
  localparam logic [2:0] QEI_M_TIMER = 3'h0;
  localparam logic [2:0] QEI_M_COUNTER = 3'h1;
  localparam logic [2:0] QEI_M_GATE_LO = 3'h2;
  localparam logic [2:0] QEI_M_GATE_HI = 3'h3;
  localparam logic [2:0] QEI_M_RELOAD = 3'h4;
  localparam logic [2:0] QEI_M_CAPTURE = 3'h5;
  localparam logic [2:0] QEI_M_QROT = 3'h6;
  localparam logic [2:0] QEI_M_QEDGE = 3'h7;
  // Input select codes
  localparam logic [2:0] QEI_I_NONE = 3'h0;
  localparam logic [2:0] QEI_I_CNT = 3'h1;
  localparam logic [2:0] QEI_I_DIR = 3'h2;
  localparam logic [2:0] QEI_I_BOTH = 3'h3;
  localparam logic [15:0] QEI_CNT_MAX = 16'hffff;
  localparam logic [15:0] QEI_CNT_MIN = 16'h0000;
  localparam logic [15:0] QEI_ONE = 16'h0001;
endpackage

// ---- rtl/qei_timer.sv ----
// Quadrature encoder core timer with two auxiliary timers and an APB slave.
`timescale 1ns/1ns
module qei_timer (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // APB slave
  input wire logic [15:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Encoder and timer inputs, index qei_pkg::QEI_AUX_A / QEI_CORE / QEI_AUX_B
  input wire logic [2:0] count_input_pin,
  input wire logic [2:0] direction_input_pin,
  // Interrupt requests, one-cycle pulses
  output logic core_interrupt_request,
  output logic aux_a_interrupt_request,
  output logic aux_b_interrupt_request
);
  import qei_pkg::*;

  typedef struct packed {
    logic [2:0][15:0] ctl;
    logic [2:0][15:0] cnt;
    logic [2:0] cin_prev;
    logic [2:0] din_prev;
    logic [2:0] irq;
    logic [31:0] rdata;
  } qei_state_t;

  qei_state_t st_q;
  qei_state_t st_d;

  // Address decode, shared by read and write paths
  function automatic logic [3:0] qei_decode(input logic [15:0] a);
    case (a)
      QEI_AUX_A_CTL: qei_decode = 4'h0;
      QEI_CORE_CTL: qei_decode = 4'h1;
      QEI_AUX_B_CTL: qei_decode = 4'h2;
      QEI_AUX_A_CNT: qei_decode = 4'h3;
      QEI_CORE_CNT: qei_decode = 4'h4;
      QEI_AUX_B_CNT: qei_decode = 4'h5;
      default: qei_decode = 4'hf;
    endcase
  endfunction

  // One step up or down, wrapping modulo 16 bits
  function automatic logic [15:0] qei_step(input logic [15:0] v, input logic down);
    qei_step = down ? v - QEI_ONE : v + QEI_ONE; // RL25
  endfunction

  logic [3:0] sel_d;
  logic acc_w;
  logic setup_c;
  logic [2:0] cin_e;
  logic [2:0] din_e;
  logic [2:0] run;
  logic [2:0] cnt_en;
  logic [2:0] down;
  logic core_wrap;
  logic [2:0] m;
  logic [2:0] isel;
  logic qdown;
  logic qcnt;
  logic [2:0] set_ch;
  logic [2:0] set_ed;

  // Zero wait states; unmapped addresses answer with an error
  assign sel_d = qei_decode(paddr);
  assign pready = 1'b1;
  assign pslverr = psel && penable && (sel_d == 4'hf);
  assign acc_w = psel && penable && pwrite && (sel_d != 4'hf);
  assign setup_c = psel && !penable;
  assign prdata = st_q.rdata;
  assign core_interrupt_request = st_q.irq[QEI_CORE];
  assign aux_a_interrupt_request = st_q.irq[QEI_AUX_A];
  assign aux_b_interrupt_request = st_q.irq[QEI_AUX_B];

  // Edge detect against the previous sample; inputs are already synchronous
  assign cin_e = count_input_pin ^ st_q.cin_prev; // RL25
  assign din_e = direction_input_pin ^ st_q.din_prev; // RL25

  // Per-timer count decision; fields are decoded identically for every timer except the remote run bit, which the core ignores
  always_comb begin
    run = '0;
    cnt_en = '0;
    down = '0;
    set_ch = '0;
    set_ed = '0;
    m = '0;
    isel = '0;
    qdown = 1'b0;
    qcnt = 1'b0;
    for (int t = 0; t < QEI_NTIM; t++) begin
      m = st_q.ctl[t][QEI_F_M_LO +: 3]; // RL19
      isel = st_q.ctl[t][QEI_F_I_LO +: 3];
      // The core run bit may also drive an auxiliary timer
      if (t != QEI_CORE && st_q.ctl[t][QEI_F_RC]) begin
        run[t] = st_q.ctl[QEI_CORE][QEI_F_RUN]; // RL17
      end else begin
        run[t] = st_q.ctl[t][QEI_F_RUN];
      end
      // Software or external direction, the up/down bit inverting the pin
      down[t] = st_q.ctl[t][QEI_F_UDE] ?
                (direction_input_pin[t] ^ st_q.ctl[t][QEI_F_UD]) :
                st_q.ctl[t][QEI_F_UD];
      case (m)
        QEI_M_TIMER: begin
          cnt_en[t] = run[t]; // RL15
        end
        QEI_M_GATE_LO, QEI_M_GATE_HI: begin
          cnt_en[t] = run[t] && (count_input_pin[t] == m[0]); // RL15
        end
        QEI_M_COUNTER: begin
          // Select bit 2 is the core overflow path, handled after the core step
          case (isel)
            3'h1: cnt_en[t] = run[t] && cin_e[t] && count_input_pin[t];
            3'h2: cnt_en[t] = run[t] && cin_e[t] && !count_input_pin[t];
            3'h3: cnt_en[t] = run[t] && cin_e[t];
            default: cnt_en[t] = 1'b0;
          endcase
        end
        QEI_M_QROT, QEI_M_QEDGE: begin // RL1
          // A simultaneous edge on both pins is illegal for an encoder; not counted
          if (cin_e[t] && !din_e[t] && (isel == QEI_I_CNT || isel == QEI_I_BOTH)) begin
            qcnt = 1'b1; // RL2 RL3
            qdown = !(count_input_pin[t] ^ direction_input_pin[t]); // RL12
          end else if (din_e[t] && !cin_e[t] && (isel == QEI_I_DIR || isel == QEI_I_BOTH)) begin
            qcnt = 1'b1; // RL2 RL3
            qdown = direction_input_pin[t] ^ count_input_pin[t]; // RL13
          end else begin
            qcnt = 1'b0;
            qdown = 1'b0;
          end
          // Inversion only applies with the external source enabled
          qdown = qdown ^ (st_q.ctl[t][QEI_F_UDE] & st_q.ctl[t][QEI_F_UD]); // RL24
          cnt_en[t] = run[t] && qcnt; // RL4
          down[t] = qdown; // RL4 RL14
          set_ed[t] = cnt_en[t]; // RL22
          set_ch[t] = cnt_en[t] && (qdown != st_q.ctl[t][QEI_F_RDIR]); // RL26
        end
        default: begin
          cnt_en[t] = 1'b0; // Reload and capture hold the auxiliary count
        end
      endcase
    end
  end

  // Core wrap feeds concatenation and reload of the auxiliary timers
  assign core_wrap = cnt_en[QEI_CORE] &&
                     (down[QEI_CORE] ? st_q.cnt[QEI_CORE] == QEI_CNT_MIN :
                                       st_q.cnt[QEI_CORE] == QEI_CNT_MAX);

  // Next state: counts, status flags, interrupts, bus writes and read data
  always_comb begin
    st_d = st_q;
    st_d.cin_prev = count_input_pin;
    st_d.din_prev = direction_input_pin;
    st_d.irq = '0;
    for (int t = 0; t < QEI_NTIM; t++) begin
      if (cnt_en[t]) begin
        st_d.cnt[t] = qei_step(st_q.cnt[t], down[t]); // RL25 RL14
      end
      if (t != QEI_CORE) begin
        // Concatenation: count on core overflow or underflow
        if (st_q.ctl[t][QEI_F_M_LO +: 3] == QEI_M_COUNTER && st_q.ctl[t][QEI_F_I_LO + 2] &&
            st_q.ctl[t][QEI_F_I_LO +: 2] != 2'h0 && run[t] && core_wrap) begin
          st_d.cnt[t] = qei_step(st_q.cnt[t], down[t]); // RL16
        end
        // Capture: the selected edge of the auxiliary input latches the core count
        if (st_q.ctl[t][QEI_F_M_LO +: 3] == QEI_M_CAPTURE && cin_e[t] &&
            ((st_q.ctl[t][QEI_F_I_LO] && count_input_pin[t]) ||
             (st_q.ctl[t][QEI_F_I_LO + 1] && !count_input_pin[t]))) begin
          st_d.cnt[t] = st_q.cnt[QEI_CORE]; // RL16
        end
      end
    end
    // Reload: a wrapping core timer restarts from an auxiliary count
    if (core_wrap && st_q.ctl[QEI_AUX_A][QEI_F_M_LO +: 3] == QEI_M_RELOAD) begin
      st_d.cnt[QEI_CORE] = st_q.cnt[QEI_AUX_A]; // RL16
    end else if (core_wrap && st_q.ctl[QEI_AUX_B][QEI_F_M_LO +: 3] == QEI_M_RELOAD) begin
      st_d.cnt[QEI_CORE] = st_q.cnt[QEI_AUX_B]; // RL16
    end
    // Bus writes; set by hardware wins over a software clear in the same cycle
    if (acc_w) begin
      if (sel_d < 4'h3) begin
        st_d.ctl[sel_d[1:0]] = (st_q.ctl[sel_d[1:0]] & ~QEI_CTL_WMASK) |
                               (pwdata[15:0] & QEI_CTL_WMASK);
      end else begin
        st_d.cnt[sel_d[1:0] - 2'h3] = pwdata[15:0]; // RL18
      end
    end
    for (int t = 0; t < QEI_NTIM; t++) begin
      if (set_ch[t]) begin
        st_d.ctl[t][QEI_F_CHDIR] = 1'b1; // RL21
      end
      if (set_ed[t]) begin
        st_d.ctl[t][QEI_F_EDGE] = 1'b1; // RL22
      end
      if (set_ed[t]) begin
        st_d.ctl[t][QEI_F_RDIR] = down[t]; // RL26 RL7
      end
      // Interrupt choice follows the mode code; disable bit gates both sources
      if (!st_q.ctl[t][QEI_F_IRDIS]) begin // RL23
        if (st_q.ctl[t][QEI_F_M_LO +: 3] == QEI_M_QROT) begin
          st_d.irq[t] = set_ch[t]; // RL5
        end else if (st_q.ctl[t][QEI_F_M_LO +: 3] == QEI_M_QEDGE) begin
          st_d.irq[t] = set_ed[t]; // RL6
        end
      end
    end
    // Read data captured in the setup phase, shown through the access phase
    if (setup_c) begin
      case (sel_d)
        4'h0, 4'h1, 4'h2: st_d.rdata = {16'h0000, st_q.ctl[sel_d[1:0]]}; // RL7
        4'h3, 4'h4, 4'h5: st_d.rdata = {16'h0000, st_q.cnt[sel_d[1:0] - 2'h3]}; // RL18
        default: st_d.rdata = 32'h0000_0000;
      endcase
    end
  end

  // No toggle latch and no output pin exist for any timer here
  always_ff @(posedge mclk) begin // RL20
    if (rst) begin
      st_q.ctl <= {QEI_NTIM{QEI_CTL_RESET}};
      st_q.cnt <= {QEI_NTIM{QEI_CNT_RESET}};
      st_q.cin_prev <= 3'h0;
      st_q.din_prev <= 3'h0;
      st_q.irq <= 3'h0;
      st_q.rdata <= 32'h0000_0000;
    end else begin
      st_q <= st_d;
    end
  end

  // Checks on the core timer in quadrature mode and on the remote run of auxiliary timer A
  logic core_quad;
  assign core_quad = st_q.ctl[QEI_CORE][QEI_F_M_LO + 1 +: 2] == 2'h3;

  property p_quad_step;
    @(posedge mclk) disable iff (rst)
    (core_quad && st_q.ctl[QEI_CORE][QEI_F_RUN] && cin_e[QEI_CORE] && !din_e[QEI_CORE] &&
     st_q.ctl[QEI_CORE][QEI_F_I_LO] && !st_q.ctl[QEI_CORE][QEI_F_I_LO + 2] && !acc_w &&
     !core_wrap)
    |=> (st_q.cnt[QEI_CORE] == $past(st_q.cnt[QEI_CORE]) + 16'h0001) ||
        (st_q.cnt[QEI_CORE] == $past(st_q.cnt[QEI_CORE]) - 16'h0001);
  endproperty
  a_quad_step: assert property (p_quad_step) else $error("core count did not step by one"); // RL2

  property p_sel_none;
    @(posedge mclk) disable iff (rst)
    (core_quad && st_q.ctl[QEI_CORE][QEI_F_I_LO +: 3] == QEI_I_NONE && !acc_w)
    |=> $stable(st_q.cnt[QEI_CORE]);
  endproperty
  a_sel_none: assert property (p_sel_none) else $error("core counted with select none"); // RL3

  property p_cnt_dir;
    @(posedge mclk) disable iff (rst)
    (core_quad && cnt_en[QEI_CORE] && cin_e[QEI_CORE] && !st_q.ctl[QEI_CORE][QEI_F_UD])
    |-> down[QEI_CORE] == (count_input_pin[QEI_CORE] == direction_input_pin[QEI_CORE]);
  endproperty
  a_cnt_dir: assert property (p_cnt_dir) else $error("count pin edge direction wrong"); // RL12

  property p_dir_dir;
    @(posedge mclk) disable iff (rst)
    (core_quad && cnt_en[QEI_CORE] && din_e[QEI_CORE] && !st_q.ctl[QEI_CORE][QEI_F_UD])
    |-> down[QEI_CORE] == (direction_input_pin[QEI_CORE] != count_input_pin[QEI_CORE]);
  endproperty
  a_dir_dir: assert property (p_dir_dir) else $error("direction pin edge direction wrong"); // RL13

  property p_irq_rot;
    @(posedge mclk) disable iff (rst)
    (st_q.ctl[QEI_CORE][QEI_F_M_LO +: 3] == QEI_M_QROT && !st_q.ctl[QEI_CORE][QEI_F_IRDIS] &&
     set_ch[QEI_CORE]) |=> core_interrupt_request;
  endproperty
  a_irq_rot: assert property (p_irq_rot) else $error("no interrupt on direction change"); // RL5

  property p_irq_edge;
    @(posedge mclk) disable iff (rst)
    (st_q.ctl[QEI_CORE][QEI_F_M_LO +: 3] == QEI_M_QEDGE && !st_q.ctl[QEI_CORE][QEI_F_IRDIS] &&
     set_ed[QEI_CORE]) |=> core_interrupt_request;
  endproperty
  a_irq_edge: assert property (p_irq_edge) else $error("no interrupt on count edge"); // RL6

  property p_irq_dis;
    @(posedge mclk) disable iff (rst)
    st_q.ctl[QEI_CORE][QEI_F_IRDIS] |=> !core_interrupt_request;
  endproperty
  a_irq_dis: assert property (p_irq_dis) else $error("interrupt while disabled"); // RL23

  property p_edge_sticky;
    @(posedge mclk) disable iff (rst)
    (st_q.ctl[QEI_CORE][QEI_F_EDGE] && !acc_w) |=> st_q.ctl[QEI_CORE][QEI_F_EDGE];
  endproperty
  a_edge_sticky: assert property (p_edge_sticky) else $error("edge flag lost"); // RL22

  property p_ch_set;
    @(posedge mclk) disable iff (rst)
    set_ch[QEI_CORE] |=> st_q.ctl[QEI_CORE][QEI_F_CHDIR] &&
                         (st_q.ctl[QEI_CORE][QEI_F_RDIR] != $past(st_q.ctl[QEI_CORE][QEI_F_RDIR]));
  endproperty
  a_ch_set: assert property (p_ch_set) else $error("direction change not recorded"); // RL21

  property p_remote;
    @(posedge mclk) disable iff (rst)
    st_q.ctl[QEI_AUX_A][QEI_F_RC] |-> run[QEI_AUX_A] == st_q.ctl[QEI_CORE][QEI_F_RUN];
  endproperty
  a_remote: assert property (p_remote) else $error("remote run not followed"); // RL17

  c_rot_irq: cover property (@(posedge mclk) disable iff (rst)
    core_interrupt_request && st_q.ctl[QEI_CORE][QEI_F_M_LO +: 3] == QEI_M_QROT);
  c_edge_irq: cover property (@(posedge mclk) disable iff (rst)
    core_interrupt_request && st_q.ctl[QEI_CORE][QEI_F_M_LO +: 3] == QEI_M_QEDGE);
  c_jitter: cover property (@(posedge mclk) disable iff (rst)
    set_ch[QEI_CORE] ##[1:20] set_ch[QEI_CORE]);
  c_wrap: cover property (@(posedge mclk) disable iff (rst) core_wrap);
endmodule
